// >>> adcps_sequencer.sv
// Power-mode and startup sequencer of the serial converter, with its AXI4-Lite registers.
`timescale 1ns/1ps
module adcps_sequencer (
    // Clock and reset.
    input  logic                    sys_clk_in,
    input  logic                    resetn_in,
    // AXI4-Lite write channels.
    input  logic [31:0]             s_axi_awaddr_in,
    input  logic                    s_axi_awvalid_in,
    output logic                    s_axi_awready_out,
    input  logic [31:0]             s_axi_wdata_in,
    input  logic [3:0]              s_axi_wstrb_in,
    input  logic                    s_axi_wvalid_in,
    output logic                    s_axi_wready_out,
    output logic [1:0]              s_axi_bresp_out,
    output logic                    s_axi_bvalid_out,
    input  logic                    s_axi_bready_in,
    // AXI4-Lite read channels.
    input  logic [31:0]             s_axi_araddr_in,
    input  logic                    s_axi_arvalid_in,
    output logic                    s_axi_arready_out,
    output logic [31:0]             s_axi_rdata_out,
    output logic [1:0]              s_axi_rresp_out,
    output logic                    s_axi_rvalid_out,
    input  logic                    s_axi_rready_in,
    // Serial pins from the host.
    input  logic                    sclk_in,
    input  logic                    cs_n_in,
    input  logic                    din_in,
    output logic                    dout_out,
    output logic                    dout_oe_out,
    output logic                    conversion_strobe_out,
    output logic                    conversion_strobe_oe_out,
    // Shutdown pin, seen as a driven level plus a float detector.
    input  logic                    shutdown_pin_in,
    input  logic                    shutdown_float_in,
    // Registered status snapshot.
    output adcps_pkg::adcps_status_t status_out
);
    import adcps_pkg::*;

    logic [4:0]    pin_s1_reg;
    logic [4:0]    pin_s2_reg;
    logic          sclk_d_reg;
    logic          sclk_s;
    logic          cs_n_s;
    logic          din_s;
    logic          shutdown_pin_pin_s;
    logic          shutdown_pin_float_s;
    logic          sclk_rise;
    logic          sclk_fall;
    logic          shutdown_pin_low;
    adcps_state_t  state_reg;
    logic [3:0]    bitcnt_reg;
    logic [7:0]    ctrl_reg;
    logic          clk_ext_reg;
    logic          pd_after_reg;
    logic          fast_pd_reg;
    logic [3:0]    conv_cnt_reg;
    logic [9:0]    div_cnt_reg;
    logic [9:0]    div_lim;
    logic          conv_tick;
    logic          conv_step;
    logic          conv_start;
    logic          conv_ext;
    logic          conv_done;
    logic [11:0]   out_sr_reg;
    logic [11:0]   result_reg;
    logic          dout_reg;
    logic          converted_reg;
    logic          strobe_reg;
    logic          comp_ext_reg;
    logic [10:0]   rst_cnt_reg;
    logic [11:0]   sample_reg;
    adcps_status_t status_now;
    adcps_status_t status_reg;
    logic          aw_got_reg;
    logic          w_got_reg;
    logic [31:0]   awaddr_reg;
    logic [31:0]   wdata_reg;
    logic [3:0]    wstrb_reg;
    logic          bvalid_reg;
    logic [1:0]    bresp_reg;
    logic          rvalid_reg;
    logic [31:0]   rdata_reg;
    logic [1:0]    rresp_reg;
    logic          wr_fire;

    // Every host pin crosses two flops; only the second stage is read.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pin_s1_reg <= PIN_RST;
            pin_s2_reg <= PIN_RST;
            sclk_d_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {shutdown_float_in, shutdown_pin_in, din_in, cs_n_in, sclk_in};
            pin_s2_reg <= pin_s1_reg;
            sclk_d_reg <= pin_s2_reg[0];
        end
    end

    // Synchronised pin levels and serial clock edges.
    assign sclk_s       = pin_s2_reg[0];
    assign cs_n_s       = pin_s2_reg[1];
    assign din_s        = pin_s2_reg[2];
    assign shutdown_pin_pin_s   = pin_s2_reg[3];
    assign shutdown_pin_float_s = pin_s2_reg[4];
    assign sclk_rise    = sclk_s && !sclk_d_reg;
    assign sclk_fall    = !sclk_s && sclk_d_reg;
    assign shutdown_pin_low     = !shutdown_pin_pin_s && !shutdown_pin_float_s;

    // Conversion start, its clock mode, and its completion.
    assign conv_start = (state_reg == ST_SHIFT) && (bitcnt_reg == CTRL_BITS)
                        && sclk_fall && !cs_n_s && !shutdown_pin_low;
    assign conv_ext   = pd_keeps_power(ctrl_reg[1:0]) ? ctrl_reg[0] : clk_ext_reg;
    assign conv_step  = clk_ext_reg ? sclk_fall : conv_tick;
    assign conv_done  = (state_reg == ST_CONV) && conv_step && !shutdown_pin_low
                        && (conv_cnt_reg == CONV_STEPS - 4'h1);

    // Power and framing state machine; a low shutdown pin beats everything.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_reg    <= ST_IDLE;
            bitcnt_reg   <= 4'h0;
            ctrl_reg     <= 8'h00;
            clk_ext_reg  <= 1'b0;
            pd_after_reg <= 1'b0;
            fast_pd_reg  <= 1'b0;
            conv_cnt_reg <= 4'h0;
        end else if (shutdown_pin_low) begin
            state_reg    <= ST_HWPD;
            bitcnt_reg   <= 4'h0;
            conv_cnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                ST_HWPD: begin
                    state_reg   <= ST_IDLE;
                    clk_ext_reg <= 1'b0;
                end
                ST_IDLE, ST_SWPD: begin
                    if (!cs_n_s && sclk_rise && din_s) begin
                        state_reg  <= ST_SHIFT;
                        ctrl_reg   <= 8'h01;
                        bitcnt_reg <= 4'h1;
                    end
                end
                ST_SHIFT: begin
                    if (cs_n_s) begin
                        state_reg  <= ST_IDLE;
                        bitcnt_reg <= 4'h0;
                    end else if (sclk_rise && bitcnt_reg != CTRL_BITS) begin
                        ctrl_reg   <= {ctrl_reg[6:0], din_s};
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end else if (conv_start) begin
                        state_reg    <= ST_CONV;
                        bitcnt_reg   <= 4'h0;
                        conv_cnt_reg <= 4'h0;
                        clk_ext_reg  <= conv_ext;
                        pd_after_reg <= !ctrl_reg[1];
                        fast_pd_reg  <= ctrl_reg[0];
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        // Power-down only after the last step.
                        state_reg    <= pd_after_reg ? ST_SWPD : ST_IDLE;
                        conv_cnt_reg <= 4'h0;
                    end else if (conv_step) begin
                        conv_cnt_reg <= conv_cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Internal conversion clock rate follows the shutdown pin state.
    assign div_lim   = shutdown_pin_float_s ? DIV_FAST : DIV_SLOW;
    assign conv_tick = (state_reg == ST_CONV) && !clk_ext_reg
                       && (div_cnt_reg == div_lim - 10'h001);

    // Divider runs only during an internal-clock conversion, saving power elsewhere.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            div_cnt_reg <= 10'h000;
        end else if (state_reg != ST_CONV || clk_ext_reg || conv_tick) begin
            div_cnt_reg <= 10'h000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 10'h001;
        end
    end

    // Result shifting; the port keeps working in software power-down.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            out_sr_reg    <= 12'h000;
            result_reg    <= 12'h000;
            dout_reg      <= 1'b0;
            converted_reg <= 1'b0;
        end else begin
            if ((conv_start && conv_ext) || (conv_done && !clk_ext_reg)) begin
                out_sr_reg    <= sample_reg;
                result_reg    <= sample_reg;
                converted_reg <= 1'b1;
            end else if (sclk_fall && !cs_n_s) begin
                out_sr_reg <= {out_sr_reg[10:0], 1'b0};
            end
            if (sclk_fall && !cs_n_s) begin
                dout_reg <= converted_reg ? out_sr_reg[11] : 1'b0;
            end
        end
    end

    // Strobe: low while converting internally, one serial period high externally.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            strobe_reg <= 1'b1;
        end else if (shutdown_pin_low) begin
            strobe_reg <= 1'b0;
        end else if (state_reg == ST_HWPD) begin
            strobe_reg <= 1'b1;
        end else if (conv_start) begin
            strobe_reg <= conv_ext;
        end else if (conv_done && !clk_ext_reg) begin
            strobe_reg <= 1'b1;
        end else if (clk_ext_reg && sclk_fall) begin
            strobe_reg <= 1'b0;
        end
    end

    // Compensation choice and the internal reset interval after power returns.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            comp_ext_reg <= 1'b0;
            rst_cnt_reg  <= 11'h000;
        end else begin
            comp_ext_reg <= shutdown_pin_float_s;
            if (state_reg == ST_HWPD) begin
                rst_cnt_reg <= 11'h000;
            end else if (rst_cnt_reg != RESET_CYCLES) begin
                rst_cnt_reg <= rst_cnt_reg + 11'h001;
            end
        end
    end

    // Pin drivers; the strobe floats with select high only in external mode.
    assign dout_out                 = dout_reg;
    assign dout_oe_out              = !cs_n_s;
    assign conversion_strobe_out    = strobe_reg;
    assign conversion_strobe_oe_out = clk_ext_reg ? !cs_n_s : 1'b1;

    // Status snapshot, registered for the port and the bus.
    assign status_now = '{reset_busy: rst_cnt_reg != RESET_CYCLES,
                          converted: converted_reg,
                          comp_external: comp_ext_reg,
                          clk_external: clk_ext_reg,
                          fast_power_down: fast_pd_reg,
                          state: state_reg};

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_now;
        end
    end
    assign status_out = status_reg;

    // Write address and data may arrive in either order; hold each until both are in.
    assign s_axi_awready_out = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready_out  = !w_got_reg && !bvalid_reg;
    assign wr_fire           = aw_got_reg && w_got_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_in;
                wstrb_reg <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= (reg_select(awaddr_reg) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out  = bresp_reg;

    // Sample word that the next conversion returns; byte lanes honoured.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sample_reg <= SAMPLE_RST;
        end else if (wr_fire && reg_select(awaddr_reg) == SEL_CTRL) begin
            if (wstrb_reg[0]) sample_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1]) sample_reg[11:8] <= wdata_reg[11:8];
        end
    end

    // Read channel answers one cycle after the address is taken.
    assign s_axi_arready_out = !rvalid_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            unique case (reg_select(s_axi_araddr_in))
                SEL_CTRL:   rdata_reg <= {20'h0_0000, sample_reg};
                SEL_STATUS: rdata_reg <= {24'h00_0000, status_reg};
                SEL_RESULT: rdata_reg <= {20'h0_0000, result_reg};
                SEL_NONE: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out  = rdata_reg;
    assign s_axi_rresp_out  = rresp_reg;

    // Checks on the sequencer behaviour.
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence ctrl_byte_done_s;
        conv_start;
    endsequence

    sequence last_step_s;
        conv_done && !$past(shutdown_pin_low);
    endsequence

    strobe_at_reset_a: assert property ($rose(resetn_in) |->
        conversion_strobe_out && state_reg == ST_IDLE && !clk_ext_reg)
        else $error("Strobe or mode wrong after reset.");

    start_bit_a: assert property ((state_reg == ST_IDLE || state_reg == ST_SWPD)
        && !cs_n_s && sclk_rise && din_s && !shutdown_pin_low
        |=> state_reg == ST_SHIFT && bitcnt_reg == 4'h1)
        else $error("Start bit not taken.");

    zero_before_conv_a: assert property (!converted_reg |-> !dout_out)
        else $error("Data out not zero before first conversion.");

    comp_select_a: assert property (shutdown_pin_float_s [*2] |-> comp_ext_reg)
        else $error("Compensation does not follow shutdown pin.");

    clock_rate_a: assert property (conv_tick |->
        div_cnt_reg == (shutdown_pin_float_s ? DIV_FAST : DIV_SLOW) - 10'h001)
        else $error("Conversion clock divider wrong.");

    swpd_no_conv_a: assert property (state_reg == ST_SWPD && !(sclk_rise && din_s)
        |=> state_reg != ST_CONV)
        else $error("Conversion in software power-down.");

    hw_shutdown_a: assert property (shutdown_pin_low |=>
        state_reg == ST_HWPD && conv_cnt_reg == 4'h0 && !conversion_strobe_out)
        else $error("Shutdown did not abort at once.");

    pd_after_conv_a: assert property (last_step_s |=>
        state_reg == ($past(pd_after_reg) ? ST_SWPD : ST_IDLE))
        else $error("Wrong state after conversion.");

    conv_begin_a: assert property (ctrl_byte_done_s |=> state_reg == ST_CONV
        && pd_after_reg == !$past(ctrl_reg[1])
        && conversion_strobe_out == $past(conv_ext))
        else $error("Conversion did not begin properly.");

    serial_active_a: assert property (state_reg == ST_SWPD && sclk_fall
        && !cs_n_s && converted_reg && !shutdown_pin_low |=> dout_out == $past(out_sr_reg[11]))
        else $error("Serial port idle in power-down.");
endmodule

// >>> adcps_pkg.sv
// Package for the converter power-mode sequencer: constants, types and decode helpers.
// Function
// - Leaving reset with shutdown not low: internal clock mode, strobe high.
// - With strobe high and select low, the first 1 on data in starts a byte.
// - Data out shifts only zeros until a first conversion has happened.
// - Floating shutdown pin selects external compensation, full 2MHz serial clock.
// - High shutdown pin selects internal compensation; host keeps 2MHz or 400kHz limits.
// - Power-mode bits pick full or fast power-down; no conversions there.
// - Low shutdown pin forces complete shutdown, overriding the power-mode bits.
// - Software power-down waits for the running conversion to finish first.
// - In internal clock mode the serial port stays active during power-down.
// - A start bit during software power-down powers the converter up.
// - Upper power bit 1 keeps power; both 0 powers down after one conversion.
// - Shutdown going low aborts a running conversion at once.
// - Internal conversion clock runs at 1.8MHz with the shutdown pin floating.
// - Internal conversion clock runs at 225kHz with the shutdown pin high.
// - Power bits: 00 full down, 01 fast down, 10 internal, 11 external clock.
// - Conversion begins on the serial clock fall after the eighth control bit.
package adcps_pkg;
    localparam int unsigned SYS_CLK_HZ    = 125_000_000;
    localparam int unsigned CONV_FAST_HZ  = 1_800_000;
    localparam int unsigned CONV_SLOW_HZ  = 225_000;
    localparam logic [9:0]  DIV_FAST      = 10'(SYS_CLK_HZ / CONV_FAST_HZ);
    localparam logic [9:0]  DIV_SLOW      = 10'(SYS_CLK_HZ / CONV_SLOW_HZ);
    localparam int unsigned RESET_TIME_NS = 10_000;
    localparam logic [10:0] RESET_CYCLES  =
        11'((RESET_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000);
    localparam logic [3:0]  CTRL_BITS     = 4'h8;
    localparam logic [3:0]  CONV_STEPS    = 4'hC;
    localparam logic [4:0]  PIN_RST       = 5'h0A;
    localparam logic [11:0] SAMPLE_RST    = 12'h000;
    localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
    localparam logic [31:0] ADDR_RESULT   = 32'h0000_0008;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [1:0]  SEL_CTRL      = 2'h0;
    localparam logic [1:0]  SEL_STATUS    = 2'h1;
    localparam logic [1:0]  SEL_RESULT    = 2'h2;
    localparam logic [1:0]  SEL_NONE      = 2'h3;

    typedef enum logic [2:0] {
        ST_HWPD  = 3'b000,
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_CONV  = 3'b011,
        ST_SWPD  = 3'b100
    } adcps_state_t;

    typedef struct packed {
        logic       reset_busy;
        logic       converted;
        logic       comp_external;
        logic       clk_external;
        logic       fast_power_down;
        logic [2:0] state;
    } adcps_status_t;

    // Upper power-mode bit set means the converter stays powered.
    function automatic logic pd_keeps_power(input logic [1:0] pd);
        return pd[1];
    endfunction

    // Word decode of an AXI byte address onto the register select.
    function automatic logic [1:0] reg_select(input logic [31:0] addr);
        logic [1:0] sel;
        sel = SEL_NONE;
        if (addr[31:2] == ADDR_CTRL[31:2]) sel = SEL_CTRL;
        if (addr[31:2] == ADDR_STATUS[31:2]) sel = SEL_STATUS;
        if (addr[31:2] == ADDR_RESULT[31:2]) sel = SEL_RESULT;
        return sel;
    endfunction
endpackage

// >>> adcps_host.sv
// Serial host model that frames control bytes and clocks results out of the converter.
`timescale 1ns/1ps
module adcps_host (
    // Host clock.
    input  logic clk_in,
    // Serial pins.
    input  logic dout_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out
);
    // Idle levels: link clock parked low and select released.
    initial begin
        sclk_out = 1'h0;
        cs_n_out = 1'h1;
        din_out  = 1'h0;
    end

    // Holds off any start bit until a power-up delay has run out in host cycles.
    task automatic power_up_wait(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // One frame of n bits, sent MSB first from tx[23]; 8 host cycles a bit is 64 ns.
    task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h00_0000;
        @(posedge clk_in);
        cs_n_out <= 1'h0;
        repeat (4) @(posedge clk_in);
        for (int j = 0; j < n; j++) begin
            din_out <= tx[23-j];
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'h1;
            repeat (2) @(posedge clk_in);
            rx = {rx[22:0], dout_in};
            repeat (2) @(posedge clk_in);
            sclk_out <= 1'h0;
        end
        // Let the last fall reach the converter before the select is released.
        repeat (8) @(posedge clk_in);
        cs_n_out <= 1'h1;
        din_out  <= ~din_out;
    endtask
endmodule

// >>> adc_power_mode_sequencer_bench.sv
// Self-checking bench of the converter power-mode sequencer.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module adc_power_mode_sequencer_bench;
    import adcps_pkg::*;
    typedef struct packed {
        logic [1:0]  pd;
        logic        flt;
        logic [11:0] word;
        logic [9:0]  div;
        logic [2:0]  state;
        logic        ext;
    } adcps_row_t;
    logic          sys_clk_in, resetn_in, shutdown_pin_in, shutdown_float_in;
    logic [31:0]   s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out, rd;
    logic          s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
    logic          s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic          s_axi_rvalid_out, s_axi_rready_in, sclk_in, cs_n_in, din_in, dout_out;
    logic          conversion_strobe_out, conversion_strobe_oe_out, dout_oe_out;
    logic [1:0]    s_axi_bresp_out, s_axi_rresp_out, resp;
    logic [3:0]    s_axi_wstrb_in;
    logic [23:0]   rx;
    adcps_status_t status_out;
    adcps_row_t    rows [5];
    int            failures, checked, low_cycles;

    adcps_sequencer u_adcps_sequencer (.sys_clk_in, .resetn_in, .s_axi_awaddr_in,
        .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
        .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
        .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .sclk_in,
        .cs_n_in, .din_in, .dout_out, .dout_oe_out, .conversion_strobe_out,
        .conversion_strobe_oe_out, .shutdown_pin_in, .shutdown_float_in, .status_out);
    adcps_host u_adcps_host (.clk_in(sys_clk_in), .dout_in(dout_out), .sclk_out(sclk_in),
        .cs_n_out(cs_n_in), .din_out(din_in));

    // 125 MHz system clock.
    initial begin
        sys_clk_in = 1'h0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    // Counts strobe-low cycles so the conversion length can be judged.
    always @(posedge sys_clk_in) if (conversion_strobe_out === 1'h0) low_cycles <= low_cycles + 1;

    // Write both halves at once; each half is released on its own acceptance.
    // No cycle limit of its own: only the watchdog ends a hung bus.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_in);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= d;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in  <= 1'h1;
        s_axi_bready_in  <= 1'h1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (s_axi_bvalid_out !== 1'h1);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
    endtask

    // Single read; the answer is taken at the edge that shows rvalid.
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_in);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in  <= 1'h1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while (s_axi_rvalid_out !== 1'h1);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
    endtask

    // Bounded wait for the end of an internal-clock conversion.
    task automatic wait_strobe();
        int n;
        n = 0;
        while (conversion_strobe_out !== 1'h1 && n < 10000) begin
            @(posedge sys_clk_in);
            n++;
        end
        `CHK("strobe_end", 1'h1, conversion_strobe_out)
    endtask

    task automatic end_of_test();
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog sized well above the roughly 40000 cycles the sequence needs.
    initial begin
        #500_000;
        failures++;
        end_of_test();
    end

    // Main sequence: reset, table of power modes, then the hardware shutdown case.
    initial begin
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        s_axi_wstrb_in = 4'hF;
        {shutdown_pin_in, shutdown_float_in} = 2'h3;
        {failures, checked, low_cycles} = '0;
        rows = '{'{2'h2, 1'h1, 12'hA5C, DIV_FAST, ST_IDLE, 1'h0},
                 '{2'h2, 1'h0, 12'h3F1, DIV_SLOW, ST_IDLE, 1'h0},
                 '{2'h0, 1'h1, 12'h800, DIV_FAST, ST_SWPD, 1'h0},
                 '{2'h1, 1'h1, 12'h001, DIV_FAST, ST_SWPD, 1'h0},
                 '{2'h3, 1'h1, 12'hFFF, 10'h000, ST_IDLE, 1'h1}};
        resetn_in = 1'h0;
        repeat (5) @(posedge sys_clk_in);
        resetn_in <= 1'h1;
        repeat (4) @(posedge sys_clk_in);
        `CHK("rst_strobe", 1'h1, conversion_strobe_out)
        `CHK("rst_state", ST_IDLE, status_out.state)
        `CHK("rst_oe", 2'h1, {dout_oe_out, conversion_strobe_oe_out})
        axi_read(ADDR_CTRL, rd, resp);
        `CHK("ctrl_rst", 12'h000, rd[11:0])
        axi_write(32'h0000_0010, 32'h0000_0001, resp);
        `CHK("wr_unmapped", RESP_SLVERR, resp)
        axi_read(32'h0000_0010, rd, resp);
        `CHK("rd_unmapped", {RESP_SLVERR, 32'h0000_0000}, {resp, rd})
        // The model's reference capacitor starts charged, so the discharged start-up is not run.
        u_adcps_host.power_up_wait(25000);
        `CHK("reset_busy", 1'h0, status_out.reset_busy)
        u_adcps_host.xfer(16, 24'h00_0000, rx);
        `CHK("dout_zero", 16'h0000, rx[15:0])
        `CHK("no_start", ST_IDLE, status_out.state)
        foreach (rows[i]) begin
            shutdown_float_in <= rows[i].flt;
            axi_write(ADDR_CTRL, {20'h0_0000, rows[i].word}, resp);
            u_adcps_host.power_up_wait(625);
            low_cycles = 0;
            if (rows[i].div != 10'h000) begin
                u_adcps_host.xfer(8, {6'h20, rows[i].pd, 16'h0000}, rx);
                wait_strobe();
                `CHK("conv_len", 1'h1, low_cycles >= 11 * rows[i].div && low_cycles <= 13 * rows[i].div)
                u_adcps_host.xfer(16, 24'h00_0000, rx);
            end else u_adcps_host.xfer(24, {6'h20, rows[i].pd, 16'h0000}, rx);
            `CHK("dout_word", {rows[i].word, 3'h0}, rx[14:0])
            repeat (8) @(posedge sys_clk_in);
            `CHK("state", rows[i].state, status_out.state)
            `CHK("clk_ext", rows[i].ext, status_out.clk_external)
            `CHK("comp_ext", rows[i].flt, status_out.comp_external)
            `CHK("oe", {1'h0, !rows[i].ext}, {dout_oe_out, conversion_strobe_oe_out})
            if (!rows[i].pd[1]) `CHK("fast_pd", rows[i].pd[0], status_out.fast_power_down)
        end
        axi_read(ADDR_RESULT, rd, resp);
        `CHK("result", {RESP_OKAY, 12'hFFF}, {resp, rd[11:0]})
        shutdown_float_in <= 1'h0;
        u_adcps_host.xfer(8, {8'h82, 16'h0000}, rx);
        repeat (20) @(posedge sys_clk_in);
        shutdown_pin_in <= 1'h0;
        repeat (6) @(posedge sys_clk_in);
        `CHK("hw_state", ST_HWPD, status_out.state)
        `CHK("hw_strobe", 1'h0, conversion_strobe_out)
        u_adcps_host.xfer(8, {8'h82, 16'h0000}, rx);
        `CHK("hw_hold", ST_HWPD, status_out.state)
        shutdown_pin_in <= 1'h1;
        u_adcps_host.power_up_wait(1300);
        `CHK("hw_exit", {ST_IDLE, 1'h1}, {status_out.state, conversion_strobe_out})
        end_of_test();
    end
endmodule
